//--- bench/hct_mem_model.sv
// hct_mem_model: transmit buffer memory answering one read at a time
// assumes: request held until ready; word bytes are the low address byte xor 00/11/22/33
`timescale 1ns/10ps
`default_nettype none
module hct_mem_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // latency select
    input wire logic slow,
    // read port
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [31:0] mem_addr,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    logic pend_r;
    logic [31:0] addr_r;
    logic [2:0] wait_r;
    // take a request, answer after a short or long wait; idle data keeps toggling
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_req_ready <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            pend_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            wait_r <= 3'h0;
        end
        else
        begin
            mem_req_ready <= mem_req_valid && !mem_req_ready && !pend_r;
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req_valid && mem_req_ready)
            begin
                pend_r <= 1'b1;
                addr_r <= mem_addr;
                wait_r <= slow ? 3'h5 : 3'h0;
            end
            else if (pend_r && wait_r != 3'h0)
                wait_r <= wait_r - 3'h1;
            else if (pend_r)
            begin
                pend_r <= 1'b0;
                mem_rvalid <= 1'b1;
                mem_rdata <= {4{addr_r[7:0]}} ^ 32'h0011_2233;
            end
        end
    end
endmodule // hct_mem_model
`default_nettype wire

//--- bench/hct_tx_channel_monitor.sv
// hct_tx_channel_monitor: assertions on buffer-read attributes and the flag/byte stream
// assumes: bound into hct_tx_channel, register writes use all byte lanes
`timescale 1ns/10ps
`default_nettype none
module hct_tx_channel_monitor import hct_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register writes
    input wire logic [HCT_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // buffer reads
    input wire logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] bus_function_code,
    input wire logic [2:0] bus_address_type,
    input wire logic big_endian_select,
    // byte stream
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_is_flag
);
    logic [HCT_AW-1:0] wa_r;
    logic [31:0] wd_r;
    logic [31:0] isw_r;
    logic [3:0] nof_r;
    logic [4:0] fcnt_r;
    logic bv_r;
    logic in_data_r;
    logic first_data;
    logic commit;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // first data byte of a frame, first cycle of a write answer
    assign first_data = tx_valid && tx_ready && !tx_is_flag && !in_data_r;
    assign commit = s_axi_bvalid && !bv_r;
    // shadow of mode and state words, length of the current flag run
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wa_r <= '0;
            wd_r <= 32'h0000_0000;
            isw_r <= 32'h0000_0000;
            nof_r <= 4'h0;
            fcnt_r <= 5'h00;
            bv_r <= 1'b0;
            in_data_r <= 1'b0;
        end
        else
        begin
            bv_r <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
                wa_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd_r <= s_axi_wdata;
            if (commit && wa_r == HCT_OFS_ISW)
                isw_r <= wd_r;
            if (commit && wa_r == HCT_OFS_MODE)
                nof_r <= wd_r[3:0];
            if (tx_valid && tx_ready)
            begin
                fcnt_r <= tx_is_flag ? fcnt_r + 5'h01 : 5'h00;
                in_data_r <= !tx_is_flag;
            end
        end
    end
    attr_fc_a: assert property ($rose(mem_req_valid) |->
        bus_function_code == isw_r[27:24]) else $error("function code differs from state word");
    attr_at_a: assert property ($rose(mem_req_valid) |->
        bus_address_type == isw_r[26:24]) else $error("address type differs from state word");
    byte_order_a: assert property ($rose(mem_req_valid) |->
        big_endian_select == isw_r[28]) else $error("byte order differs from state word");
    attr_hold_a: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid
        && $stable(mem_addr) && $stable({bus_function_code, big_endian_select}))
        else $error("buffer read dropped or changed before taken");
    flag_min_a: assert property (first_data |-> fcnt_r >= {1'b0, nof_r})
        else $error("too few flags before frame");
    flag_one_a: assert property (first_data && nof_r == 4'h0 |-> fcnt_r != 5'h00)
        else $error("no opening flag with zero count");
    flag_byte_a: assert property (tx_valid && tx_is_flag |-> tx_data == HCT_FLAG_BYTE)
        else $error("flag byte has wrong value");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("stream byte changed before taken");
    cover property ($rose(mem_req_valid) && !big_endian_select);
    cover property (first_data && nof_r == 4'h0);
    cover property (tx_valid && !tx_ready [*3]);
endmodule // hct_tx_channel_monitor
bind hct_tx_channel hct_tx_channel_monitor hct_tx_channel_monitor_i (.*);
`default_nettype wire

//--- bench/hct_tx_channel_tb.sv
// hct_tx_channel_tb: register and frame tests of the transmit channel
// assumes: hct_mem_model on the buffer port; bench is register master and byte sink
`timescale 1ns/10ps
`default_nettype none
module hct_tx_channel_tb import hct_pkg::*;;
    localparam logic [31:0] BUF_BASE = 32'h0000_0100;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic mem_req_valid, mem_req_ready, big_endian_select, mem_rvalid;
    logic tx_valid, tx_ready, tx_is_flag, slow;
    logic [HCT_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_rdata;
    logic [3:0] s_axi_wstrb, bus_function_code;
    logic [2:0] bus_address_type;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] tx_data;
    logic [8:0] got_q[$];
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int stall_until = 0;
    // frame table: flag count, state word, length in words
    logic [3:0] nofs[4] = '{4'h0, 4'hf, 4'h2, 4'hc};
    logic [31:0] isws[4] = '{32'h3800_0000, 32'h3000_0000, 32'h0500_0000, 32'h3500_0000};
    logic [15:0] lens[4] = '{16'h0002, 16'h0014, 16'h0001, 16'h0003};
    hct_tx_channel #(.FIFO_DEPTH(HCT_FIFO_DEPTH)) hct_tx_channel_i (.*);
    hct_mem_model hct_mem_model_i (.*);
    // clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // byte sink with stalls, capture and run limit
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        tx_ready <= cyc >= stall_until && cyc[1:0] != 2'h3;
        if (tx_valid && tx_ready)
            got_q.push_back({tx_is_flag, tx_data});
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [HCT_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_t && w_t))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_t = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_t = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [HCT_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rdc(input logic [HCT_AW-1:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // program one frame, collect its bytes, check flags, byte order and status
    task automatic frame(input logic [3:0] min_flag_count, input logic [31:0] isw, input logic [15:0] len);
        int nf, nd, k;
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] r;
        got_q.delete();
        wr(HCT_OFS_MODE, {28'h0, min_flag_count}, HCT_RESP_OKAY);
        wr(HCT_OFS_ISW, isw, HCT_RESP_OKAY);
        rdc(HCT_OFS_ISW, isw, HCT_RESP_OKAY);
        wr(HCT_OFS_BUF_ADDR, BUF_BASE, HCT_RESP_OKAY);
        wr(HCT_OFS_BUF_LEN, {16'h0, len}, HCT_RESP_OKAY);
        wr(HCT_OFS_CTRL, 32'h0000_0001, HCT_RESP_OKAY);
        wr(HCT_OFS_CTRL, 32'h0000_0003, HCT_RESP_OKAY);
        do
        begin
            @(posedge aclk);
            nd = 0;
            foreach (got_q[i]) nd += int'(!got_q[i][8]);
        end while (nd < 4 * len);
        nf = 0;
        while (got_q[nf][8]) nf++;
        chk({31'h0, nf >= ((min_flag_count == 4'h0) ? 1 : int'(min_flag_count))}, 32'h1);
        chk({23'h0, got_q[0]}, {23'h0, 1'b1, HCT_FLAG_BYTE});
        for (int j = 0; j < 4 * len; j++)
        begin
            a = BUF_BASE[7:0] + 8'(4 * (j / 4));
            k = isw[HCT_BE_BIT] ? j % 4 : 3 - j % 4;
            chk({23'h0, got_q[nf + j]}, {24'h0, a ^ (8'(k) * 8'h11)});
        end
        do rd(HCT_OFS_STATUS, d, r); while (d[1] !== 1'b1);
        chk(d, {23'h0, isw[28], isw[27:24], 4'h6});
        wr(HCT_OFS_CTRL, 32'h0000_0000, HCT_RESP_OKAY);
    endtask
    // reset, register checks, then the frame table
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(HCT_OFS_MODE, {16'h0, HCT_MODE_RST}, HCT_RESP_OKAY);
        rdc(HCT_OFS_ISW, HCT_ISW_RST, HCT_RESP_OKAY);
        rdc(8'h40, 32'h0000_0000, HCT_RESP_SLVERR);
        wr(8'h40, 32'hffff_ffff, HCT_RESP_SLVERR);
        wr(HCT_OFS_MODE, 32'hffff_abc5, HCT_RESP_OKAY);
        rdc(HCT_OFS_MODE, 32'h0000_abc5, HCT_RESP_OKAY);
        wr(HCT_OFS_STATUS, 32'hffff_ffff, HCT_RESP_OKAY);
        rdc(HCT_OFS_STATUS, 32'h0000_0000, HCT_RESP_OKAY);
        $display("test 0 done");
        for (int t = 0; t < 4; t++)
        begin
            slow <= t[0];
            stall_until = (t == 1) ? cyc + 300 : 0;
            frame(nofs[t], isws[t], lens[t]);
            $display("test %0d done", t + 1);
        end
        tally_and_finish();
    end
endmodule // hct_tx_channel_tb
`default_nettype wire

//--- rtl/hct_pkg.sv
// hct_pkg: register map, field positions, reset values, types of the transmit channel
// assumes: data 32 bits, register bus addresses of HCT_AW bits, byte addressed
package hct_pkg;
    // register byte offsets
    localparam int HCT_AW = 8;
    localparam logic [HCT_AW-1:0] HCT_OFS_MODE = 8'h00;
    localparam logic [HCT_AW-1:0] HCT_OFS_ISW = 8'h04;
    localparam logic [HCT_AW-1:0] HCT_OFS_CTRL = 8'h08;
    localparam logic [HCT_AW-1:0] HCT_OFS_BUF_ADDR = 8'h0c;
    localparam logic [HCT_AW-1:0] HCT_OFS_BUF_LEN = 8'h10;
    localparam logic [HCT_AW-1:0] HCT_OFS_STATUS = 8'h14;
    // field positions, physical bit 0 is the least significant bit
    localparam int HCT_MINFLAG_LSB = 0;
    localparam int HCT_BE_BIT = 28;
    localparam int HCT_FC_LSB = 24;
    localparam int HCT_AT_LSB = 24;
    localparam int HCT_CTRL_EN_BIT = 0;
    localparam int HCT_CTRL_START_BIT = 1;
    // reset values and constants
    localparam logic [15:0] HCT_MODE_RST = 16'h0000;
    localparam logic [31:0] HCT_ISW_RST = 32'h0000_0000;
    localparam logic [7:0] HCT_FLAG_BYTE = 8'h7e;
    localparam logic [4:0] HCT_MIN_FLAGS = 5'h01;
    localparam logic [31:0] HCT_WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] HCT_RESP_OKAY = 2'h0;
    localparam logic [1:0] HCT_RESP_SLVERR = 2'h2;
    localparam int HCT_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {HCT_IDLE, HCT_FLAGS, HCT_DATA} hct_phase_e;

    // attributes of one transmit buffer read
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] fc;
        logic [2:0] at;
        logic big_endian;
    } hct_mem_req_s;

    // one byte on the serial side
    typedef struct packed {
        logic [7:0] data;
        logic is_flag;
    } hct_tx_s;

    // whole state of the channel top
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic w_held;
        logic [HCT_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] mode;
        logic [31:0] isw;
        logic enable;
        logic busy;
        logic done;
        logic [31:0] buf_addr;
        logic [15:0] buf_len;
        hct_phase_e phase;
        logic [4:0] flags_left;
        logic [15:0] words_left;
        logic [15:0] fetch_left;
        logic [31:0] fetch_addr;
        logic mem_pending;
        logic mem_req_valid;
        hct_mem_req_s mem_req;
        logic [31:0] hold_word;
        logic hold_valid;
        logic [1:0] byte_idx;
        logic tx_valid;
        hct_tx_s tx;
    } hct_state_s;
endpackage

//--- rtl/hct_tx_channel.sv
// hct_tx_channel: transmit channel with register slave, buffer fetch, word fifo, flag/byte sender
// assumes: AXI4-Lite master on aclk, memory port answers one read at a time, sink on tx_*
// Overview of operation
// - send at least min_flag_count flags before frames
// - zero count still sends one opening flag
// - big_endian_select picks buffer byte order
// - bus_function_code driven on every buffer read
// - bus_address_type driven on every buffer read
// - fields placed with bit 0 least significant
`timescale 1ns/10ps
`default_nettype none

module hct_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [PW-1:0] LAST = PW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } fifo_state_s;

    fifo_state_s s_r;
    fifo_state_s s_nxt;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (s_r.count != FULL);
    assign out_valid = (s_r.count != '0);
    assign out_data = s_r.mem[s_r.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = (s_r.wr == LAST) ? '0 : s_r.wr + 1'b1;
        end
        if (pop)
            s_nxt.rd = (s_r.rd == LAST) ? '0 : s_r.rd + 1'b1;
        if (push && !pop)
            s_nxt.count = s_r.count + 1'b1;
        else if (pop && !push)
            s_nxt.count = s_r.count - 1'b1;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule // hct_fifo

module hct_tx_channel import hct_pkg::*; #(
    parameter int FIFO_DEPTH = HCT_FIFO_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus, write
    input wire logic [HCT_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus, read
    input wire logic [HCT_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transmit buffer read port toward the memory controller
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [31:0] mem_addr,
    output logic [3:0] bus_function_code,
    output logic [2:0] bus_address_type,
    output logic big_endian_select,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // byte stream toward the serial side
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_is_flag
);
    hct_state_s s_r;
    hct_state_s s_nxt;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;

    // byte-lane merge of a register write
    function automatic logic [31:0] hct_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[8*i +: 8] = new_v[8*i +: 8];
        return res;
    endfunction

    // words land in the fifo in wire order, lane 0 sent first
    assign fifo_in_valid = mem_rvalid && s_r.mem_pending;
    assign fifo_in_data = s_r.mem_req.big_endian ?
        {mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16], mem_rdata[31:24]} :
        mem_rdata;
    assign fifo_out_ready = (s_r.phase == HCT_DATA) && !s_r.hold_valid;

    hct_fifo #(
        .W(32),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // bus slave, buffer fetch and byte sender
    always_comb
    begin
        logic [31:0] wval;
        logic advance;
        logic start;
        wval = '0;
        start = 1'b0;
        s_nxt = s_r;
        advance = !s_r.tx_valid || tx_ready;

        // write address and data are caught in either order
        if (s_axi_awvalid && s_r.awready)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready)
        begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid)
        begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = HCT_RESP_OKAY;
            unique case (s_r.awaddr)
                HCT_OFS_MODE:
                begin
                    wval = hct_merge({16'h0000, s_r.mode}, s_r.wdata, s_r.wstrb);
                    s_nxt.mode = wval[15:0];
                end
                HCT_OFS_ISW: s_nxt.isw = hct_merge(s_r.isw, s_r.wdata, s_r.wstrb);
                HCT_OFS_CTRL:
                begin
                    if (s_r.wstrb[0])
                    begin
                        s_nxt.enable = s_r.wdata[HCT_CTRL_EN_BIT];
                        start = s_r.wdata[HCT_CTRL_START_BIT];
                    end
                end
                HCT_OFS_BUF_ADDR:
                    s_nxt.buf_addr = hct_merge(s_r.buf_addr, s_r.wdata, s_r.wstrb);
                HCT_OFS_BUF_LEN:
                begin
                    wval = hct_merge({16'h0000, s_r.buf_len}, s_r.wdata, s_r.wstrb);
                    s_nxt.buf_len = wval[15:0];
                end
                HCT_OFS_STATUS: s_nxt.bresp = HCT_RESP_OKAY;
                default: s_nxt.bresp = HCT_RESP_SLVERR;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_held;
        s_nxt.wready = !s_nxt.w_held;

        // register reads, one at a time
        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_r.arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = HCT_RESP_OKAY;
            unique case (s_axi_araddr)
                HCT_OFS_MODE: s_nxt.rdata = {16'h0000, s_r.mode};
                HCT_OFS_ISW: s_nxt.rdata = s_r.isw;
                HCT_OFS_CTRL: s_nxt.rdata = {31'h0000_0000, s_r.enable};
                HCT_OFS_BUF_ADDR: s_nxt.rdata = s_r.buf_addr;
                HCT_OFS_BUF_LEN: s_nxt.rdata = {16'h0000, s_r.buf_len};
                HCT_OFS_STATUS:
                    s_nxt.rdata = {23'h000000, s_r.mem_req.big_endian, s_r.mem_req.fc,
                        1'b0, s_r.enable, s_r.done, s_r.busy};
                default:
                begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = HCT_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;

        // a start on an enabled idle channel with a nonzero buffer length opens a frame with flags
        if (start && s_r.enable && !s_r.busy && s_r.buf_len != '0)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.phase = HCT_FLAGS;
            s_nxt.flags_left = (s_r.mode[HCT_MINFLAG_LSB +: 4] == 4'h0) ? HCT_MIN_FLAGS :
                {1'b0, s_r.mode[HCT_MINFLAG_LSB +: 4]};
            s_nxt.fetch_left = s_r.buf_len;
            s_nxt.words_left = s_r.buf_len;
            s_nxt.fetch_addr = s_r.buf_addr;
        end

        // buffer fetch, one read under way, only with room in the fifo
        if (s_r.mem_req_valid && mem_req_ready)
        begin
            s_nxt.mem_req_valid = 1'b0;
            s_nxt.mem_pending = 1'b1;
            s_nxt.fetch_addr = s_r.fetch_addr + HCT_WORD_STEP;
            s_nxt.fetch_left = s_r.fetch_left - 16'h0001;
        end
        else if (s_r.busy && s_r.enable && !s_r.mem_req_valid && !s_r.mem_pending &&
            s_r.fetch_left != '0 && fifo_in_ready)
        begin
            s_nxt.mem_req_valid = 1'b1;
            s_nxt.mem_req.addr = s_r.fetch_addr;
            s_nxt.mem_req.big_endian = s_r.isw[HCT_BE_BIT];
            s_nxt.mem_req.fc = s_r.isw[HCT_FC_LSB +: 4];
            s_nxt.mem_req.at = s_r.isw[HCT_AT_LSB +: 3];
        end
        if (fifo_in_valid)
            s_nxt.mem_pending = 1'b0;

        // byte sender: flags first, then buffer bytes
        if (advance)
            s_nxt.tx_valid = 1'b0;
        unique case (s_r.phase)
            HCT_IDLE: s_nxt.hold_valid = 1'b0;
            HCT_FLAGS:
            begin
                if (advance && s_r.flags_left != '0)
                begin
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx.data = HCT_FLAG_BYTE;
                    s_nxt.tx.is_flag = 1'b1;
                    s_nxt.flags_left = s_r.flags_left - 5'h01;
                end
                else if (advance)
                    s_nxt.phase = HCT_DATA;
            end
            HCT_DATA:
            begin
                if (fifo_out_valid && fifo_out_ready && s_r.words_left != '0)
                begin
                    s_nxt.hold_word = fifo_out_data;
                    s_nxt.hold_valid = 1'b1;
                    s_nxt.byte_idx = 2'h0;
                    s_nxt.words_left = s_r.words_left - 16'h0001;
                end
                else if (s_r.hold_valid && advance)
                begin
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx.data = s_r.hold_word[8*s_r.byte_idx +: 8];
                    s_nxt.tx.is_flag = 1'b0;
                    s_nxt.byte_idx = s_r.byte_idx + 2'h1;
                    if (s_r.byte_idx == 2'h3)
                        s_nxt.hold_valid = 1'b0;
                end
                else if (!s_r.hold_valid && s_r.words_left == '0 && advance)
                begin
                    s_nxt.phase = HCT_IDLE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.mode <= HCT_MODE_RST;
            s_r.isw <= HCT_ISW_RST;
            s_r.phase <= HCT_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from the state register
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign mem_req_valid = s_r.mem_req_valid;
    assign mem_addr = s_r.mem_req.addr;
    assign bus_function_code = s_r.mem_req.fc;
    assign bus_address_type = s_r.mem_req.at;
    assign big_endian_select = s_r.mem_req.big_endian;
    assign tx_valid = s_r.tx_valid;
    assign tx_data = s_r.tx.data;
    assign tx_is_flag = s_r.tx.is_flag;
endmodule // hct_tx_channel

`default_nettype wire
